/* File: bench/rtrcd_host_model.sv */
// host microcontroller model acting as master of the serial command link
`timescale 1ns/100ps
module rtrcd_host_model (
  output logic     sck,
  output logic     chip_select_n,
  output logic     sdi,
  input  wire logic sdo
);
  localparam int HALF_SCK = 6;

  // serial clock stands still low between frames
  initial begin
    sck = 1'b0;
    chip_select_n = 1'b1;
    sdi = 1'b0;
  end

  // data changes only while sck is low, so each rising edge sees settled data
  task automatic shift8(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      sdi = b[i];
      #HALF_SCK sck = 1'b1;
      #HALF_SCK sck = 1'b0;
    end
  endtask

  // a released data line shows the inverse of its last value, never a stale copy
  task automatic end_frame();
    #HALF_SCK chip_select_n = 1'b1;
    sdi = ~sdi;
    #100;
  endtask

  task automatic send_word(input logic [15:0] w);
    chip_select_n = 1'b0;
    #HALF_SCK;
    shift8(w[15:8]);
    shift8(w[7:0]);
    end_frame();
  endtask

  // bounded polls: a flag that never moves must not hang the host
  task automatic wait_sdo(input logic lvl);
    for (int k = 0; k < 400 && sdo !== lvl; k++) #HALF_SCK;
  endtask

  // command byte once, then bytes straight into the holding register
  task automatic send_stream(input logic [7:0] b0, input logic [7:0] b1);
    chip_select_n = 1'b0;
    #HALF_SCK;
    shift8(rtrcd_pkg::TX_CMD);
    wait_sdo(1'b1);
    shift8(b0);
    wait_sdo(1'b0);
    wait_sdo(1'b1);
    shift8(b1);
    end_frame();
  endtask
endmodule

/* File: bench/tb_rtrcd_top.sv */
// self-checking testbench of the radio tuning command decoder
`timescale 1ns/100ps
module tb_rtrcd_top;
  localparam int LIMIT = 20000;
  localparam int BW_EXP[8]  = '{0, 400, 340, 270, 200, 134, 67, 0};
  localparam int GN_EXP[4]  = '{0, 6, 14, 20};
  localparam int TH_EXP[8]  = '{103, 97, 91, 85, 79, 73, 0, 0};
  localparam int MULT[4]    = '{1, 1, 2, 3};
  localparam int OFFS[4]    = '{31, 43, 43, 30};

  logic              clk, reset, ce, sck, chip_select_n, sdi, cr_locked, tx_byte_taken;
  logic [1:0]        band_sel;
  logic signed [7:0] sig_level_dbm;
  logic              sdo, tx_full, pin16_role_select, vdi_resp_active, signal_above_threshold;
  logic              auto_clock_recovery_lock, clock_recovery_fast_select, cr_fast_mode;
  logic              baseband_filter_type;
  logic [7:0]        tx_data;
  logic [11:0]       channel_word;
  logic [21:0]       centre_freq_half_khz;
  logic [1:0]        vdi_resp_time;
  logic [8:0]        bb_bw_khz;
  logic [4:0]        lna_gain_red_db, cr_min_preamble;
  logic [6:0]        signal_thr_mag_dbm;
  logic [2:0]        data_quality_level;
  int                fails, checks_done, cycles;

  rtrcd_top u_rtrcd_top (.clk(clk), .reset(reset), .ce(ce), .sck(sck),
    .chip_select_n(chip_select_n), .sdi(sdi), .band_sel(band_sel),
    .sig_level_dbm(sig_level_dbm), .cr_locked(cr_locked), .tx_byte_taken(tx_byte_taken),
    .sdo(sdo), .tx_data(tx_data), .tx_full(tx_full), .channel_word(channel_word),
    .centre_freq_half_khz(centre_freq_half_khz), .pin16_role_select(pin16_role_select),
    .vdi_resp_time(vdi_resp_time), .vdi_resp_active(vdi_resp_active),
    .bb_bw_khz(bb_bw_khz), .lna_gain_red_db(lna_gain_red_db),
    .signal_thr_mag_dbm(signal_thr_mag_dbm), .signal_above_threshold(signal_above_threshold),
    .auto_clock_recovery_lock(auto_clock_recovery_lock),
    .clock_recovery_fast_select(clock_recovery_fast_select), .cr_fast_mode(cr_fast_mode),
    .cr_min_preamble(cr_min_preamble), .baseband_filter_type(baseband_filter_type),
    .data_quality_level(data_quality_level));

  rtrcd_host_model u_rtrcd_host_model (.sck(sck), .chip_select_n(chip_select_n),
    .sdi(sdi), .sdo(sdo));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles >= LIMIT) begin
      fails++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // frame, then settle past the synchroniser and the centre frequency stage
  task automatic wr(input logic [15:0] w);
    u_rtrcd_host_model.send_word(w);
    cyc(6);
  endtask

  task automatic t_reset_values();
    chk(32'(channel_word), 32'h0000_0680, "chan por");
    chk(32'(bb_bw_khz), 200, "bw por");
    chk(32'(signal_thr_mag_dbm), 103, "thr por");
    chk(32'(data_quality_level), 4, "dq por");
    chk(32'(cr_min_preamble), 12, "pre por");
  endtask

  task automatic t_freq();
    wr(16'ha640);
    chk(32'(channel_word), 32'h0000_0640, "chan");
    wr(16'ha05f);
    chk(32'(channel_word), 32'h0000_0640, "below range");
    wr(16'haf40);
    chk(32'(channel_word), 32'h0000_0640, "above range");
    wr(16'ha060);
    chk(32'(channel_word), 32'h0000_0060, "low edge");
    wr(16'haf3f);
    chk(32'(channel_word), 32'h0000_0f3f, "high edge");
  endtask

  task automatic t_band();
    for (int b = 0; b < 4; b++) begin
      @(negedge clk) band_sel = 2'(b);
      cyc(3);
      chk(32'(centre_freq_half_khz), MULT[b] * (20000 * OFFS[b] + 5 * 3903), "fc");
    end
    // a low clock enable must hold the centre frequency against a band change
    @(negedge clk) ce = 1'b0;
    band_sel = 2'h0;
    cyc(3);
    chk(32'(centre_freq_half_khz), MULT[3] * (20000 * OFFS[3] + 5 * 3903), "fc frozen");
    ce = 1'b1;
    cyc(3);
    chk(32'(centre_freq_half_khz), MULT[0] * (20000 * OFFS[0] + 5 * 3903), "fc thawed");
  endtask

  task automatic t_rxc();
    logic [2:0] c;
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      wr({5'h12, c[0], c[2:1], c, c[1:0], c});
      chk(32'(pin16_role_select), 32'(c[0]), "role");
      chk(32'(vdi_resp_time), 32'(c[2:1]), "vdir");
      chk(32'(vdi_resp_active), 32'(c[0]), "vdir active");
      chk(32'(bb_bw_khz), BW_EXP[i], "bw");
      chk(32'(lna_gain_red_db), GN_EXP[i % 4], "gain");
      chk(32'(signal_thr_mag_dbm), TH_EXP[i], "thr");
    end
  endtask

  task automatic lvl(input logic signed [7:0] v, input logic exp);
    @(negedge clk) sig_level_dbm = v;
    cyc(3);
    chk(32'(signal_above_threshold), 32'(exp), "above flag");
  endtask

  task automatic t_threshold();
    wr(16'h9000);
    lvl(-8'sd102, 1'b1);
    lvl(-8'sd103, 1'b0);
    wr(16'h900a);
    lvl(-8'sd84, 1'b1);
    lvl(-8'sd85, 1'b0);
    wr(16'h9006);
    lvl(8'sd20, 1'b0);
  endtask

  task automatic mode(input logic lk, input logic fast);
    @(negedge clk) cr_locked = lk;
    cyc(3);
    chk(32'(cr_fast_mode), 32'(fast), "cr mode");
    chk(32'(cr_min_preamble), fast ? 6 : 12, "preamble");
  endtask

  task automatic t_filter();
    wr(16'hc2d7);
    chk(32'(auto_clock_recovery_lock), 1, "auto");
    chk(32'(clock_recovery_fast_select), 1, "fast sel");
    chk(32'(baseband_filter_type), 1, "baseband_filter_type");
    chk(32'(data_quality_level), 7, "dq");
    mode(1'b0, 1'b1);
    mode(1'b1, 1'b0);
    wr(16'hc240);
    mode(1'b1, 1'b1);
    wr(16'hc200);
    chk(32'(baseband_filter_type), 0, "baseband_filter_type dig");
    mode(1'b0, 1'b0);
  endtask

  // a receiver control write (9088), then near-miss prefixes that must leave the channel, bandwidth, gain and threshold alone
  task automatic t_unknown();
    wr(16'h9088);
    wr(16'h3123);
    wr(16'h9800);
    wr(16'hb000);
    chk(32'(channel_word), 32'h0000_0f3f, "chan kept");
    chk(32'(bb_bw_khz), 200, "bw kept");
    chk(32'(lna_gain_red_db), 6, "gain kept");
    chk(32'(signal_thr_mag_dbm), 103, "thr kept");
  endtask

  task automatic wait_full();
    for (int k = 0; k < 300 && tx_full !== 1'b1; k++) @(negedge clk);
  endtask

  task automatic take();
    @(negedge clk) tx_byte_taken = 1'b1;
    @(negedge clk) tx_byte_taken = 1'b0;
  endtask

  task automatic t_stream();
    fork
      u_rtrcd_host_model.send_stream(8'h55, 8'ha3);
      begin
        wait_full();
        chk(32'(tx_data), 32'h0000_0055, "byte 1");
        cyc(2);
        chk(32'(sdo), 0, "sdo full");
        take();
        cyc(3);
        chk(32'(sdo), 1, "sdo empty");
        wait_full();
        chk(32'(tx_data), 32'h0000_00a3, "byte 2");
        take();
      end
    join
    cyc(4);
    chk(32'(sdo), 0, "sdo idle");
    chk(32'(tx_full), 0, "drained");
  endtask

  initial begin
    fails = 0;
    checks_done = 0;
    cycles = 0;
    reset = 1'b1;
    ce = 1'b1;
    band_sel = 2'h0;
    sig_level_dbm = -8'sd120;
    cr_locked = 1'b0;
    tx_byte_taken = 1'b0;
    cyc(10);
    reset = 1'b0;
    cyc(4);
    t_reset_values();
    t_freq();
    t_band();
    t_rxc();
    t_threshold();
    t_filter();
    t_unknown();
    t_stream();
    report_and_stop();
  end
endmodule

/* File: logic/rtrcd_pkg.sv */
// constants shared by the radio tuning command decoder
package rtrcd_pkg;
  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;
  localparam int EV_W   = WORD_W + 1;
  localparam int CNT_W  = 5;
  localparam int FREQ_W = 12;
  localparam int RXC_W  = 11;
  localparam int FC_W   = 22;

  // command prefixes
  localparam logic [3:0] FREQ_CMD = 4'ha;
  localparam logic [4:0] RXC_CMD  = 5'h12;
  localparam logic [7:0] BBF_CMD  = 8'hc2;
  localparam logic [7:0] TX_CMD   = 8'hb8;

  // power-on values
  localparam logic [15:0] FREQ_POR = 16'ha680;
  localparam logic [15:0] RXC_POR  = 16'h9080;
  localparam logic [15:0] BBF_POR  = 16'hc22c;

  // accepted channel word range, 96 to 3903
  localparam logic [11:0] FREQ_MIN = 12'h060;
  localparam logic [11:0] FREQ_MAX = 12'hf3f;

  // receiver control fields
  localparam int RXC_ROLE = 10;
  localparam int VDIR_HI  = 9;
  localparam int VDIR_LO  = 8;
  localparam int BB_HI    = 7;
  localparam int BB_LO    = 5;
  localparam int GAIN_HI  = 4;
  localparam int GAIN_LO  = 3;
  localparam int THR_HI   = 2;
  localparam int THR_LO   = 0;

  // baseband filter fields
  localparam int BBF_AUTO = 7;
  localparam int BBF_FAST = 6;
  localparam int BBF_BASEBAND_FILTER_TYPE = 4;
  localparam int DQ_HI    = 2;
  localparam logic [7:0] BBF_FIXED = 8'h28;

  // centre frequency in half-kHz units: 10 MHz and one channel step
  localparam int FC_PER_10MHZ = 32'h0000_4e20;
  localparam int FVAL_DIV     = 32'h0000_0fa0;
  localparam int FC_PER_FVAL  = FC_PER_10MHZ / FVAL_DIV;
  localparam logic [3:0][1:0] BAND_MULT = {2'h3, 2'h2, 2'h1, 2'h1};
  localparam logic [3:0][5:0] BAND_OFFS = {6'h1e, 6'h2b, 6'h2b, 6'h1f};

  // decode tables, index is the field code
  localparam logic [7:0][8:0] BW_KHZ = {9'h000, 9'h043, 9'h086, 9'h0c8,
                                        9'h10e, 9'h154, 9'h190, 9'h000};
  localparam logic [3:0][4:0] GAIN_DB = {5'h14, 5'h0e, 5'h06, 5'h00};
  localparam logic [7:0][6:0] THR_MAG = {7'h00, 7'h00, 7'h49, 7'h4f,
                                         7'h55, 7'h5b, 7'h61, 7'h67};
  localparam logic [2:0] THR_RESV = 3'h6;

  // least preamble lengths for clock recovery
  localparam logic [4:0] PRE_FAST = 5'h06;
  localparam logic [4:0] PRE_SLOW = 5'h0c;
endpackage

/* File: logic/rtrcd_top.sv */
// serial command decoder and receiver configuration for the fsk transceiver
`timescale 1ns/100ps

// link side: shifts command words on the serial clock, cleared by chip select
module rtrcd_link (
  input  wire logic                     sck,
  input  wire logic                     reset,
  input  wire logic                     chip_select_n,
  input  wire logic                     sdi,
  output logic [rtrcd_pkg::EV_W-1:0]    ev_word,
  output logic                          ev_toggle,
  output logic                          stream
);
  typedef struct packed {
    logic [rtrcd_pkg::CNT_W-1:0]  cnt;
    logic [rtrcd_pkg::WORD_W-1:0] shreg;
    logic                         stream;
  } rtrcd_frame_s;

  typedef struct packed {
    logic [rtrcd_pkg::EV_W-1:0] word;
    logic                       tog;
  } rtrcd_event_s;

  rtrcd_frame_s                 fr_q, fr_d;
  rtrcd_event_s                 ev_q, ev_d;
  logic [rtrcd_pkg::WORD_W-1:0] sh;

  // the serial clock stops between frames, so frame state is cleared by the
  // frame's own chip select; the event word must outlive the frame
  always_comb begin
    fr_d = fr_q;
    ev_d = ev_q;
    sh   = {fr_q.shreg[rtrcd_pkg::WORD_W-2:0], sdi};
    fr_d.shreg = sh;
    if (!fr_q.stream) begin
      if (fr_q.cnt != rtrcd_pkg::CNT_W'(rtrcd_pkg::WORD_W)) begin
        fr_d.cnt = fr_q.cnt + 1'b1;
      end
      if (fr_q.cnt == rtrcd_pkg::CNT_W'(rtrcd_pkg::BYTE_W - 1) &&
          sh[rtrcd_pkg::BYTE_W-1:0] == rtrcd_pkg::TX_CMD) begin
        fr_d.stream = 1'b1;
        fr_d.cnt    = '0;
      end else if (fr_q.cnt == rtrcd_pkg::CNT_W'(rtrcd_pkg::WORD_W - 1)) begin
        ev_d.word = {1'b0, sh};
        ev_d.tog  = ~ev_q.tog;
      end
    end else begin
      if (fr_q.cnt == rtrcd_pkg::CNT_W'(rtrcd_pkg::BYTE_W - 1)) begin
        fr_d.cnt  = '0;
        ev_d.word = {1'b1, 8'h00, sh[rtrcd_pkg::BYTE_W-1:0]};
        ev_d.tog  = ~ev_q.tog;
      end else begin
        fr_d.cnt = fr_q.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge sck or posedge chip_select_n) begin
    if (chip_select_n) begin
      fr_q <= '0;
    end else begin
      fr_q <= fr_d;
    end
  end

  always_ff @(posedge sck or posedge reset) begin
    if (reset) begin
      ev_q <= '0;
    end else if (!chip_select_n) begin
      ev_q <= ev_d;
    end
  end

  assign ev_word   = ev_q.word;
  assign ev_toggle = ev_q.tog;
  assign stream    = fr_q.stream;
endmodule

module rtrcd_top (
  input  wire logic                       clk,
  input  wire logic                       reset,
  input  wire logic                       ce,
  input  wire logic                       sck,
  input  wire logic                       chip_select_n,
  input  wire logic                       sdi,
  input  wire logic [1:0]                 band_sel,
  input  wire logic signed [7:0]          sig_level_dbm,
  input  wire logic                       cr_locked,
  input  wire logic                       tx_byte_taken,
  output logic                            sdo,
  output logic [7:0]                      tx_data,
  output logic                            tx_full,
  output logic [rtrcd_pkg::FREQ_W-1:0]    channel_word,
  output logic [rtrcd_pkg::FC_W-1:0]      centre_freq_half_khz,
  output logic                            pin16_role_select,
  output logic [1:0]                      vdi_resp_time,
  output logic                            vdi_resp_active,
  output logic [8:0]                      bb_bw_khz,
  output logic [4:0]                      lna_gain_red_db,
  output logic [6:0]                      signal_thr_mag_dbm,
  output logic                            signal_above_threshold,
  output logic                            auto_clock_recovery_lock,
  output logic                            clock_recovery_fast_select,
  output logic                            cr_fast_mode,
  output logic [4:0]                      cr_min_preamble,
  output logic                            baseband_filter_type,
  output logic [2:0]                      data_quality_level
);
  typedef struct packed {
    logic                         cs_s1;
    logic                         cs_s2;
    logic                         cs_s3;
    logic                         tog_s1;
    logic                         tog_s2;
    logic                         tog_s3;
    logic                         str_s1;
    logic                         str_s2;
    logic                         pend_valid;
    logic [rtrcd_pkg::WORD_W-1:0] pend_word;
    logic [rtrcd_pkg::FREQ_W-1:0] freq;
    logic [rtrcd_pkg::RXC_W-1:0]  rxc;
    logic [7:0]                   bbf;
    logic [7:0]                   tx_data;
    logic                         tx_full;
    logic                         sdo;
    logic [rtrcd_pkg::FC_W-1:0]   fc;
    logic [8:0]                   bw;
    logic [4:0]                   gain;
    logic [6:0]                   thr;
    logic                         above;
    logic                         cr_fast;
    logic [4:0]                   pre;
  } rtrcd_state_s;

  rtrcd_state_s                q, d;
  logic [rtrcd_pkg::EV_W-1:0]  ev_word;
  logic                        ev_toggle;
  logic                        stream;
  logic                        ev_seen;
  logic                        cs_rise;
  logic                        cs_fall;
  logic                        byte_ev;
  logic [rtrcd_pkg::WORD_W-1:0] word;
  logic                        word_ok;

  rtrcd_link u_link (
    .sck           (sck),
    .reset         (reset),
    .chip_select_n (chip_select_n),
    .sdi           (sdi),
    .ev_word       (ev_word),
    .ev_toggle     (ev_toggle),
    .stream        (stream)
  );

  function automatic logic [rtrcd_pkg::FC_W-1:0] centre_fn(
    input logic [1:0]                 band,
    input logic [rtrcd_pkg::FREQ_W-1:0] fval
  );
    int unsigned f;
    f = rtrcd_pkg::BAND_MULT[band] * (rtrcd_pkg::FC_PER_10MHZ * rtrcd_pkg::BAND_OFFS[band]
        + rtrcd_pkg::FC_PER_FVAL * fval);
    return rtrcd_pkg::FC_W'(f);
  endfunction

  // true when the threshold code is not reserved and the signal is stronger than the threshold lifted by the gain cut
  function automatic logic above_fn(
    input logic signed [7:0] lvl,
    input logic [2:0]        code,
    input logic [1:0]        gcode
  );
    logic signed [9:0] m;
    m = 10'(lvl) + $signed({3'h0, rtrcd_pkg::THR_MAG[code]})
        - $signed({5'h00, rtrcd_pkg::GAIN_DB[gcode]});
    return (code < rtrcd_pkg::THR_RESV) && (m > 10'sh000);
  endfunction

  // ce does not stop the link, so a frame that ends while ce is low may be missed
  assign cs_rise = q.cs_s2 & ~q.cs_s3;
  assign cs_fall = ~q.cs_s2 & q.cs_s3;
  assign ev_seen = q.tog_s2 ^ q.tog_s3;
  assign byte_ev = ev_seen & ev_word[rtrcd_pkg::EV_W-1];

  always_comb begin
    d        = q;
    d.cs_s1  = chip_select_n;
    d.cs_s2  = q.cs_s1;
    d.cs_s3  = q.cs_s2;
    d.tog_s1 = ev_toggle;
    d.tog_s2 = q.tog_s1;
    d.tog_s3 = q.tog_s2;
    d.str_s1 = stream;
    d.str_s2 = q.str_s1;
    // the event word is stable long before its toggle clears the synchroniser
    if (cs_fall) begin
      d.pend_valid = 1'b0;
    end
    if (ev_seen && !byte_ev) begin
      d.pend_valid = 1'b1;
      d.pend_word  = ev_word[rtrcd_pkg::WORD_W-1:0];
    end
    if (tx_byte_taken) begin
      d.tx_full = 1'b0;
    end
    if (byte_ev) begin
      d.tx_data = ev_word[7:0];
      d.tx_full = 1'b1;          // loading wins over a same-cycle drain
    end
    word    = d.pend_word;
    word_ok = (word[11:0] >= rtrcd_pkg::FREQ_MIN) && (word[11:0] <= rtrcd_pkg::FREQ_MAX);
    if (cs_rise && d.pend_valid) begin
      d.pend_valid = 1'b0;
      if (word[15:12] == rtrcd_pkg::FREQ_CMD) begin
        if (word_ok) begin
          d.freq = word[11:0];
        end
      end else if (word[15:11] == rtrcd_pkg::RXC_CMD) begin
        d.rxc = word[rtrcd_pkg::RXC_W-1:0];
      end else if (word[15:8] == rtrcd_pkg::BBF_CMD) begin
        d.bbf = word[7:0] | rtrcd_pkg::BBF_FIXED;
      end
      // any other prefix falls through untouched
    end
    d.sdo = ~q.cs_s2 & q.str_s2 & ~q.tx_full;
    d.fc  = centre_fn(band_sel, q.freq);
    d.bw  = rtrcd_pkg::BW_KHZ[q.rxc[rtrcd_pkg::BB_HI:rtrcd_pkg::BB_LO]];
    d.gain = rtrcd_pkg::GAIN_DB[q.rxc[rtrcd_pkg::GAIN_HI:rtrcd_pkg::GAIN_LO]];
    d.thr = rtrcd_pkg::THR_MAG[q.rxc[rtrcd_pkg::THR_HI:rtrcd_pkg::THR_LO]];
    d.above = above_fn(sig_level_dbm, q.rxc[rtrcd_pkg::THR_HI:rtrcd_pkg::THR_LO],
                       q.rxc[rtrcd_pkg::GAIN_HI:rtrcd_pkg::GAIN_LO]);
    // automatic lock re-enters fast mode whenever lock is lost
    if (q.bbf[rtrcd_pkg::BBF_AUTO]) begin
      d.cr_fast = ~cr_locked;
    end else begin
      d.cr_fast = q.bbf[rtrcd_pkg::BBF_FAST];
    end
    d.pre = d.cr_fast ? rtrcd_pkg::PRE_FAST : rtrcd_pkg::PRE_SLOW;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      q       <= '0;
      q.cs_s1 <= 1'b1;
      q.cs_s2 <= 1'b1;
      q.cs_s3 <= 1'b1;
      q.freq  <= rtrcd_pkg::FREQ_POR[rtrcd_pkg::FREQ_W-1:0];
      q.rxc   <= rtrcd_pkg::RXC_POR[rtrcd_pkg::RXC_W-1:0];
      q.bbf   <= rtrcd_pkg::BBF_POR[7:0];
      q.fc    <= centre_fn(2'h0, rtrcd_pkg::FREQ_POR[rtrcd_pkg::FREQ_W-1:0]);
      q.pre   <= rtrcd_pkg::PRE_SLOW;
    end else if (ce) begin
      q <= d;
    end
  end

  assign sdo                        = q.sdo;
  assign tx_data                    = q.tx_data;
  assign tx_full                    = q.tx_full;
  assign channel_word               = q.freq;
  assign centre_freq_half_khz       = q.fc;
  assign pin16_role_select          = q.rxc[rtrcd_pkg::RXC_ROLE];
  assign vdi_resp_time              = q.rxc[rtrcd_pkg::VDIR_HI:rtrcd_pkg::VDIR_LO];
  assign vdi_resp_active            = q.rxc[rtrcd_pkg::RXC_ROLE];
  assign bb_bw_khz                  = q.bw;
  assign lna_gain_red_db            = q.gain;
  assign signal_thr_mag_dbm         = q.thr;
  assign signal_above_threshold     = q.above;
  assign auto_clock_recovery_lock   = q.bbf[rtrcd_pkg::BBF_AUTO];
  assign clock_recovery_fast_select = q.bbf[rtrcd_pkg::BBF_FAST];
  assign cr_fast_mode               = q.cr_fast;
  assign cr_min_preamble            = q.pre;
  assign baseband_filter_type       = q.bbf[rtrcd_pkg::BBF_BASEBAND_FILTER_TYPE];
  assign data_quality_level         = q.bbf[rtrcd_pkg::DQ_HI:0];

  freq_range_a: assert property (@(posedge clk) disable iff (reset)
    $changed(q.freq) |-> (q.freq >= rtrcd_pkg::FREQ_MIN && q.freq <= rtrcd_pkg::FREQ_MAX))
    else $error("channel word left the legal range");

  freq_on_cs_a: assert property (@(posedge clk) disable iff (reset)
    $changed(q.freq) |-> $past(cs_rise && ce))
    else $error("channel word changed without chip select rising");

  rxc_on_cs_a: assert property (@(posedge clk) disable iff (reset)
    $changed(q.rxc) |-> $past(cs_rise && ce) && $past(q.pend_valid || ev_seen))
    else $error("receiver control changed outside a frame end");

  bbf_on_cs_a: assert property (@(posedge clk) disable iff (reset)
    $changed(q.bbf) |-> $past(cs_rise && ce))
    else $error("filter control changed without chip select rising");

  tx_load_a: assert property (@(posedge clk) disable iff (reset)
    (ce && byte_ev) |=> (q.tx_full && q.tx_data == $past(ev_word[7:0])))
    else $error("streamed byte not loaded");

  sdo_flag_a: assert property (@(posedge clk) disable iff (reset)
    ##1 (sdo && $past(ce)) |-> $past(!q.cs_s2 && q.str_s2 && !q.tx_full))
    else $error("serial output flag without an empty holding register");

  sdo_ready_a: assert property (@(posedge clk) disable iff (reset)
    (ce && !q.cs_s2 && q.str_s2 && !q.tx_full) |=> sdo)
    else $error("serial output low while holding register empty");

  bbf_fixed_a: assert property (@(posedge clk) disable iff (reset)
    (q.bbf & rtrcd_pkg::BBF_FIXED) == rtrcd_pkg::BBF_FIXED)
    else $error("filter fixed bits not set");

  cr_auto_a: assert property (@(posedge clk) disable iff (reset)
    (ce && q.bbf[rtrcd_pkg::BBF_AUTO]) |=> (cr_fast_mode == !$past(cr_locked)))
    else $error("automatic clock recovery mode wrong");

  cr_manual_a: assert property (@(posedge clk) disable iff (reset)
    (ce && !q.bbf[rtrcd_pkg::BBF_AUTO]) |=> (cr_fast_mode == $past(q.bbf[rtrcd_pkg::BBF_FAST]))
    ##1 (!$past(ce) || cr_min_preamble == (cr_fast_mode ? rtrcd_pkg::PRE_FAST
                                                        : rtrcd_pkg::PRE_SLOW)))
    else $error("manual clock recovery mode or preamble wrong");

  rssi_cmp_a: assert property (@(posedge clk) disable iff (reset)
    (ce && q.rxc[rtrcd_pkg::THR_HI:rtrcd_pkg::THR_LO] >= rtrcd_pkg::THR_RESV)
    |=> !signal_above_threshold)
    else $error("strength flag set under a reserved threshold");
endmodule
